// [include/bml_pkg.sv]
// Shared constants and types of the boot mode loader
package bml_pkg;
	// Program space addresses
	localparam logic [23:0] RESET_VECTOR   = 24'hff0000;
	localparam logic [23:0] ROM_FIRST      = 24'hff0000;
	localparam logic [23:0] ROM_LAST       = 24'hff00bf;
	localparam int          ROM_WORDS      = 192;
	localparam logic [23:0] EXT_BOOT_BASE  = 24'hd00000;
	localparam logic [17:0] EXT_PIN_BASE   = 18'h00000;
	// External byte reads
	localparam logic [4:0]  EXT_WAIT_STATES = 5'h1f;
	// Operating control word layout and reset value
	localparam int          MA_POS         = 0;
	localparam int          MB_POS         = 1;
	localparam int          MC_POS         = 2;
	localparam int          MD_POS         = 3;
	localparam logic [23:0] OCW_RESET      = 24'h000004;
	// Edges spent filling the mode pin synchroniser after reset
	localparam logic [1:0]  LATCH_CYCLES   = 2'h2;
	// Serial framing
	localparam int          SPI_WORD_BITS  = 24;
	localparam logic [4:0]  I2C_LAST_BIT   = 5'h07;
	localparam logic [4:0]  I2C_ACK_BIT    = 5'h08;
	localparam logic [1:0]  LAST_BYTE_IDX  = 2'h2;

	typedef enum logic [3:0] {
		MODE_ROM     = 4'h4,
		MODE_BYTE    = 4'h5,
		MODE_RSV6    = 4'h6,
		MODE_RSV7    = 4'h7,
		MODE_RSVC    = 4'hc,
		MODE_SPI     = 4'hd,
		MODE_I2C_FRZ = 4'he,
		MODE_I2C     = 4'hf
	} bml_mode_t;

	typedef enum logic [2:0] {
		ST_LATCH  = 3'b000,
		ST_DECIDE = 3'b001,
		ST_EXT    = 3'b010,
		ST_SER    = 3'b011,
		ST_STORE  = 3'b100,
		ST_JUMP   = 3'b101,
		ST_RUN    = 3'b110,
		ST_HALT   = 3'b111
	} bml_state_t;

	typedef enum logic [1:0] {
		PH_COUNT = 2'b00,
		PH_ADDR  = 2'b01,
		PH_DATA  = 2'b10
	} bml_phase_t;

	typedef struct packed {
		logic        we;
		logic [23:0] addr;
		logic [23:0] data;
	} bml_program_ram_wr_t;

	typedef struct packed {
		logic       wr;
		logic [3:0] bits;
		logic       jump;
	} bml_sw_cmd_t;
endpackage : bml_pkg

// [rtl/bml_boot_loader.sv]
// Boot mode latch and program loader top
`timescale 1ns/10ps
`default_nettype none
// How it works
// (R1) Mode pins set operating mode at reset
// (R2) Reset release loads pins into mode bits
// (R3) Mode bits a b c d select boot
// (R4) Reset vector always FF0000; mode 4 ROM
// (R5) Mode 4 fetches ROM, no download
// (R6) Boot ROM spans 192 words FF0000-FF00BF
// (R7) Mode 5 reads byte memory from D00000
// (R8) Mode 5 reads use 31 wait states
// (R9) D00000 appears as pin address zero
// (R10) Stream: count, start address, then words
// (R11) Three bytes, least significant first
// (R12) Mode D: SPI slave, 24-bit words
// (R13) Mode E: I2C slave, clock freeze on
// (R14) Mode F: I2C slave, clock freeze off
// (R15) Words stored consecutively from start address
// (R16) After last word jump to start
// (R17) Software rewrites mode bits and reboots
// (R18) Software keeps mode bit c set; code copies sw_cmd_i.bits into all four mode bits, c included
// (R19) Modes 6, 7, C are reserved
// (R20) Reset sets mode bit c, bit 2
// (R21) No jump before last word written
// (R22) Pins sampled at reset release edge; code samples at first ref_clk_i edge after release, loads two edges later
module bml_boot_loader
	import bml_pkg::*;
#(
	parameter logic [4:0] EXT_WAITS = EXT_WAIT_STATES
) (
	input  wire logic         ref_clk_i,
	input  wire logic         reset_i,
	input  wire logic         link_clk_i,
	input  wire logic         mode_pin_a_i,
	input  wire logic         mode_pin_b_i,
	input  wire logic         mode_pin_d_i,
	input  wire bml_sw_cmd_t  sw_cmd_i,
	input  wire logic [7:0]   ext_data_i,
	output logic [17:0]       ext_addr_o,
	output logic              ext_rd_n_o,
	output logic              ext_aa1_n_o,
	input  wire logic         spi_ss_n_i,
	input  wire logic         serial_data_i,
	output logic              sda_o,
	output logic              sda_oe_o,
	output logic              scl_o,
	output logic              scl_oe_o,
	input  wire logic [23:0]  fetch_addr_i,
	output logic              rom_hit_o,
	output logic [7:0]        rom_index_o,
	output bml_program_ram_wr_t      program_ram_wr_o,
	output logic [23:0]       operating_control_word_o,
	output logic              run_o,
	output logic [23:0]       start_pc_o,
	output logic              boot_busy_o,
	output logic              bad_mode_o
);
	if (EXT_WAITS == 5'h00) begin : g_chk
		$error("EXT_WAITS must be at least one");
	end

	bml_state_t   state_reg;
	bml_phase_t   phase_reg;
	bml_mode_t    mode_w;
	bml_state_t   ret_w;
	logic [1:0]   lat_cnt_reg;
	logic [2:0]   pin_s1;
	logic [2:0]   pin_s2;
	logic [7:0]   dat_s1;
	logic [7:0]   dat_s2;
	logic         tg_s1;
	logic         tg_s2;
	logic         tg_s3;
	logic         pend_reg;
	logic [4:0]   cnt_reg;
	logic [1:0]   byte_idx_reg;
	logic [23:0]  asm_reg;
	logic [23:0]  val_reg;
	logic [23:0]  remain_reg;
	logic [23:0]  load_addr_reg;
	logic [23:0]  program_ram_ptr_reg;
	logic [23:0]  ser_word;
	logic         ser_toggle;
	logic [23:0]  prev_addr_reg;
	logic         wr_seen_reg;
	logic [5:0]   low_cyc_reg;
	wire  logic   lat_done_w;
	wire  logic   byte_take_w;
	wire  logic   word_stb_w;
	wire  logic   byte_stb_w;
	wire  logic [7:0] in_byte_w;

	assign mode_w      = bml_mode_t'(operating_control_word_o[3:0]);
	assign ret_w       = (mode_w == MODE_BYTE) ? ST_EXT : ST_SER;
	assign lat_done_w  = (state_reg == ST_LATCH) && (lat_cnt_reg == LATCH_CYCLES);
	assign byte_take_w = (state_reg == ST_EXT) && !ext_rd_n_o && (cnt_reg == EXT_WAITS);
	assign word_stb_w  = (state_reg == ST_SER) && pend_reg && (mode_w == MODE_SPI);
	assign byte_stb_w  = byte_take_w || ((state_reg == ST_SER) && pend_reg && (mode_w != MODE_SPI));
	assign in_byte_w   = (state_reg == ST_EXT) ? dat_s2 : ser_word[7:0];

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
			dat_s1 <= 8'h00;
			dat_s2 <= 8'h00;
			tg_s1  <= 1'b0;
			tg_s2  <= 1'b0;
			tg_s3  <= 1'b0;
		end else begin
			pin_s1 <= {mode_pin_d_i, mode_pin_b_i, mode_pin_a_i}; // see R1
			pin_s2 <= pin_s1;
			dat_s1 <= ext_data_i;
			dat_s2 <= dat_s1;
			tg_s1  <= ser_toggle;
			tg_s2  <= tg_s1;
			tg_s3  <= tg_s2;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Operating control word
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			operating_control_word_o <= OCW_RESET; // see R20
			lat_cnt_reg              <= 2'h0;
		end else begin
			if (state_reg == ST_LATCH && !lat_done_w)
				lat_cnt_reg <= 2'(lat_cnt_reg + 2'h1);
			if (lat_done_w) begin
				operating_control_word_o[MA_POS] <= pin_s2[0]; // see R2
				operating_control_word_o[MB_POS] <= pin_s2[1]; // see R22
				operating_control_word_o[MD_POS] <= pin_s2[2]; // see R2
			end else if (sw_cmd_i.wr) begin
				operating_control_word_o[3:0] <= sw_cmd_i.bits; // see R17
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// External byte-wide reads
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ext_addr_o  <= EXT_PIN_BASE;
			ext_rd_n_o  <= 1'b1;
			ext_aa1_n_o <= 1'b1;
			cnt_reg     <= 5'h00;
		end else if (state_reg == ST_DECIDE) begin
			ext_addr_o  <= EXT_PIN_BASE; // see R9
			ext_rd_n_o  <= 1'b1;
			ext_aa1_n_o <= 1'b1;
		end else if (state_reg != ST_EXT) begin
			ext_rd_n_o  <= 1'b1;
			ext_aa1_n_o <= 1'b1;
		end else if (ext_rd_n_o) begin
			ext_rd_n_o  <= 1'b0; // see R7
			ext_aa1_n_o <= 1'b0; // see R8
			cnt_reg     <= 5'h00;
		end else if (byte_take_w) begin
			ext_rd_n_o  <= 1'b1;
			ext_aa1_n_o <= 1'b1;
			ext_addr_o  <= 18'(ext_addr_o + 18'h00001);
		end else begin
			cnt_reg <= 5'(cnt_reg + 5'h01); // see R8
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial port, its crossing and clock freeze
	bml_serial_rx #(
		.WORD_BITS (SPI_WORD_BITS)
	) u_rx (
		.link_clk_i    (link_clk_i),
		.reset_i       (reset_i),
		.ss_n_i        (spi_ss_n_i),
		.data_i        (serial_data_i),
		.spi_mode_i    (mode_w == MODE_SPI),
		.word_o        (ser_word),
		.word_toggle_o (ser_toggle),
		.sda_oe_o      (sda_oe_o)
	);

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pend_reg <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_o    <= 1'b0;
			scl_o    <= 1'b0;
		end else begin
			if (tg_s2 ^ tg_s3)
				pend_reg <= 1'b1;
			else if (state_reg == ST_SER)
				pend_reg <= 1'b0;
			scl_oe_o <= pend_reg && (mode_w == MODE_I2C_FRZ); // see R13
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Boot ROM window decode
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rom_hit_o   <= 1'b0;
			rom_index_o <= 8'h00;
		end else begin
			rom_hit_o   <= (fetch_addr_i >= ROM_FIRST) && (fetch_addr_i <= ROM_LAST); // see R6
			rom_index_o <= 8'(fetch_addr_i - ROM_FIRST);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Boot sequencer
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg     <= ST_LATCH;
			phase_reg     <= PH_COUNT;
			byte_idx_reg  <= 2'h0;
			asm_reg       <= 24'h000000;
			val_reg       <= 24'h000000;
			remain_reg    <= 24'h000000;
			load_addr_reg <= 24'h000000;
			program_ram_ptr_reg  <= 24'h000000;
			program_ram_wr_o     <= '0;
			run_o         <= 1'b0;
			start_pc_o    <= RESET_VECTOR;
			boot_busy_o   <= 1'b1;
			bad_mode_o    <= 1'b0;
		end else begin
			program_ram_wr_o.we <= 1'b0;
			if (sw_cmd_i.jump) begin
				state_reg   <= ST_DECIDE; // see R17
				start_pc_o  <= RESET_VECTOR;
				run_o       <= 1'b0;
				boot_busy_o <= 1'b1;
			end else begin
				unique case (state_reg)
					ST_LATCH: begin
						if (lat_done_w)
							state_reg <= ST_DECIDE;
					end
					ST_DECIDE: begin
						phase_reg    <= PH_COUNT;
						byte_idx_reg <= 2'h0;
						bad_mode_o   <= 1'b0;
						case (mode_w) // see R3
							MODE_ROM: begin
								start_pc_o  <= ROM_FIRST; // see R4
								run_o       <= 1'b1; // see R5
								boot_busy_o <= 1'b0;
								state_reg   <= ST_RUN;
							end
							MODE_BYTE: state_reg <= ST_EXT; // see R7
							MODE_SPI, MODE_I2C_FRZ, MODE_I2C: state_reg <= ST_SER; // see R14
							default: begin
								bad_mode_o  <= 1'b1; // see R19
								boot_busy_o <= 1'b0;
								state_reg   <= ST_HALT;
							end
						endcase
					end
					ST_EXT, ST_SER: begin
						if (word_stb_w) begin
							val_reg   <= ser_word; // see R12
							state_reg <= ST_STORE;
						end else if (byte_stb_w) begin
							asm_reg <= {in_byte_w, asm_reg[23:8]}; // see R11
							if (byte_idx_reg == LAST_BYTE_IDX) begin
								val_reg      <= {in_byte_w, asm_reg[23:8]};
								byte_idx_reg <= 2'h0;
								state_reg    <= ST_STORE;
							end else begin
								byte_idx_reg <= 2'(byte_idx_reg + 2'h1);
							end
						end
					end
					ST_STORE: begin
						case (phase_reg) // see R10
							PH_COUNT: begin
								remain_reg <= val_reg;
								phase_reg  <= PH_ADDR;
								state_reg  <= ret_w;
							end
							PH_ADDR: begin
								load_addr_reg <= val_reg;
								program_ram_ptr_reg  <= val_reg;
								phase_reg     <= PH_DATA;
								state_reg     <= (remain_reg == 24'h000000) ? ST_JUMP : ret_w;
							end
							PH_DATA: begin
								program_ram_wr_o.we   <= 1'b1;
								program_ram_wr_o.addr <= program_ram_ptr_reg;
								program_ram_wr_o.data <= val_reg;
								program_ram_ptr_reg   <= 24'(program_ram_ptr_reg + 24'h000001); // see R15
								remain_reg     <= 24'(remain_reg - 24'h000001);
								state_reg      <= (remain_reg == 24'h000001) ? ST_JUMP : ret_w; // see R21
							end
							default: begin
								bad_mode_o <= 1'b1;
								state_reg  <= ST_HALT;
							end
						endcase
					end
					ST_JUMP: begin
						start_pc_o  <= load_addr_reg; // see R16
						run_o       <= 1'b1;
						boot_busy_o <= 1'b0;
						state_reg   <= ST_RUN;
					end
					ST_RUN, ST_HALT: state_reg <= state_reg;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			prev_addr_reg <= 24'h000000;
			wr_seen_reg   <= 1'b0;
		end else if (state_reg == ST_DECIDE) begin
			wr_seen_reg <= 1'b0;
		end else if (program_ram_wr_o.we) begin
			prev_addr_reg <= program_ram_wr_o.addr;
			wr_seen_reg   <= 1'b1;
		end
	end

	// Length of each read strobe, for the wait state check
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i)
			low_cyc_reg <= 6'h00;
		else if (ext_rd_n_o)
			low_cyc_reg <= 6'h00;
		else
			low_cyc_reg <= 6'(low_cyc_reg + 6'h01);
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	AST_OCW_LATCH: assert property (lat_done_w |=> operating_control_word_o[MA_POS] == $past(pin_s2[0]) // see R2
		&& operating_control_word_o[MB_POS] == $past(pin_s2[1]) && operating_control_word_o[MD_POS] == $past(pin_s2[2]))
		else $error("Mode pins not loaded into control word");
	AST_MC_SET: assert property (lat_done_w |=> operating_control_word_o[MC_POS]) // see R20
		else $error("Mode bit c not set after reset");
	AST_ROM_START: assert property (state_reg == ST_DECIDE && mode_w == MODE_ROM && !sw_cmd_i.jump // see R5
		|=> run_o && start_pc_o == ROM_FIRST && !program_ram_wr_o.we)
		else $error("Mode 4 did not start at ROM");
	AST_EXT_WAIT: assert property (@(posedge ref_clk_i) disable iff (reset_i || sw_cmd_i.jump) // see R8
		$rose(ext_rd_n_o) |-> low_cyc_reg == 6'(6'(EXT_WAITS) + 6'h01))
		else $error("External read length wrong");
	AST_EXT_FIRST: assert property (state_reg == ST_DECIDE && mode_w == MODE_BYTE && !sw_cmd_i.jump // see R9
		|=> ext_addr_o == EXT_PIN_BASE ##1 !ext_rd_n_o && ext_addr_o == EXT_PIN_BASE)
		else $error("First boot byte not at pin address zero");
	AST_PROGRAM_RAM_SEQ: assert property (program_ram_wr_o.we && wr_seen_reg |-> program_ram_wr_o.addr == 24'(prev_addr_reg + 24'h000001)) // see R15
		else $error("Program words not consecutive");
	AST_JUMP_LAST: assert property ($rose(run_o) && mode_w != MODE_ROM // see R16
		|-> remain_reg == 24'h000000 && start_pc_o == load_addr_reg)
		else $error("Jump before all words or to wrong address");
	AST_NO_EARLY_RUN: assert property ($rose(run_o) |-> !program_ram_wr_o.we && $past(state_reg) != ST_STORE) // see R21
		else $error("Control passed while a word was still being written");
	AST_RSV_HALT: assert property (state_reg == ST_DECIDE && !sw_cmd_i.jump // see R3
		&& mode_w inside {MODE_RSV6, MODE_RSV7, MODE_RSVC} |=> bad_mode_o && !run_o && state_reg == ST_HALT)
		else $error("Reserved mode not halted");
	AST_SW_REENTER: assert property (sw_cmd_i.jump |=> state_reg == ST_DECIDE && !run_o ##1 !bad_mode_o) // see R17
		else $error("Software reboot not taken");
	AST_FREEZE: assert property (scl_oe_o |-> $past(mode_w) == MODE_I2C_FRZ && $past(pend_reg)) // see R13
		else $error("Clock held outside freeze mode");
endmodule : bml_boot_loader
`default_nettype wire

// [rtl/bml_serial_rx.sv]
// Serial host port receiver on the link clock
`timescale 1ns/10ps
`default_nettype none
module bml_serial_rx
	import bml_pkg::*;
#(
	parameter int WORD_BITS = SPI_WORD_BITS
) (
	input  wire logic                 link_clk_i,
	input  wire logic                 reset_i,
	input  wire logic                 ss_n_i,
	input  wire logic                 data_i,
	input  wire logic                 spi_mode_i,
	output logic [WORD_BITS-1:0]      word_o,
	output logic                      word_toggle_o,
	output logic                      sda_oe_o
);
	localparam logic [4:0] LAST = 5'(WORD_BITS - 1);

	logic                 spi_s1;
	logic                 spi_s2;
	logic [4:0]           bit_cnt_reg;
	logic [WORD_BITS-1:0] shift_reg;
	wire  logic           frame_rst;

	if (WORD_BITS < 9 || WORD_BITS > 32) begin : g_chk
		$error("WORD_BITS out of range");
	end

	assign frame_rst = reset_i | ss_n_i;

	////////////////////////////////////////////////////////////////////////
	// Mode level from the core domain
	always_ff @(posedge link_clk_i or posedge reset_i) begin
		if (reset_i) begin
			spi_s1 <= 1'b0;
			spi_s2 <= 1'b0;
		end else begin
			spi_s1 <= spi_mode_i;
			spi_s2 <= spi_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bit counter and shifter, cleared between frames
	always_ff @(posedge link_clk_i or posedge frame_rst) begin
		if (frame_rst) begin
			bit_cnt_reg <= 5'h00;
			shift_reg   <= '0;
		end else if (spi_s2) begin
			shift_reg   <= {shift_reg[WORD_BITS-2:0], data_i};
			bit_cnt_reg <= (bit_cnt_reg == LAST) ? 5'h00 : 5'(bit_cnt_reg + 5'h01); // see R12
		end else if (bit_cnt_reg == I2C_ACK_BIT) begin
			bit_cnt_reg <= 5'h00;
		end else begin
			shift_reg   <= {shift_reg[WORD_BITS-2:0], data_i};
			bit_cnt_reg <= 5'(bit_cnt_reg + 5'h01);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Completed word or byte, flagged by a toggle
	always_ff @(posedge link_clk_i or posedge reset_i) begin
		if (reset_i) begin
			word_o        <= '0;
			word_toggle_o <= 1'b0;
			sda_oe_o      <= 1'b0;
		end else begin
			sda_oe_o <= 1'b0;
			if (spi_s2 && !ss_n_i && bit_cnt_reg == LAST) begin
				word_o        <= {shift_reg[WORD_BITS-2:0], data_i}; // see R12
				word_toggle_o <= ~word_toggle_o;
			end else if (!spi_s2 && !ss_n_i && bit_cnt_reg == I2C_LAST_BIT) begin
				word_o        <= {{(WORD_BITS-8){1'b0}}, shift_reg[6:0], data_i}; // see R13
				word_toggle_o <= ~word_toggle_o;
				sda_oe_o      <= 1'b1;
			end
		end
	end

	AST_SPI_WORD: assert property (@(posedge link_clk_i) disable iff (reset_i) // see R12
		spi_s2 && !ss_n_i && bit_cnt_reg == LAST |=> word_toggle_o != $past(word_toggle_o))
		else $error("SPI word not completed after full word of bits");
endmodule : bml_serial_rx
`default_nettype wire

// [testbench/bml_partner.sv]
// Behavioural far side: byte-wide boot memory and serial host master
`timescale 1ns/10ps
`default_nettype none
module bml_partner (
	input  wire logic [17:0] ext_addr_i,
	input  wire logic        ext_rd_n_i,
	output logic      [7:0]  ext_data_o,
	input  wire logic        sda_oe_i,
	input  wire logic        scl_oe_i,
	output logic             link_clk_o,
	output logic             ss_n_o,
	output logic             sdata_o
);
	logic [7:0] mem [0:63];
	logic [7:0] last_byte;
	logic       host_bit;
	logic       i2c;
	int         n_ack;

	initial begin
		link_clk_o = 1'b0;
		ss_n_o = 1'b1;
		host_bit = 1'b1;
		i2c = 1'b0;
		n_ack = 0;
		last_byte = 8'h00;
		for (int i = 0; i < 64; i++) mem[i] = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Released bus shows the inverse of the last byte, not a held value
	always @(ext_rd_n_i or ext_addr_i) if (!ext_rd_n_i) last_byte = mem[ext_addr_i[5:0]];
	assign ext_data_o = ext_rd_n_i ? ~last_byte : mem[ext_addr_i[5:0]];
	// Open-drain SDA with pull-up
	assign sdata_o = i2c ? (host_bit & ~sda_oe_i) : host_bit;

	////////////////////////////////////////////////////////////////////////////////
	// One SPI frame per 24-bit word, MSB first
	task automatic spi_word(input logic [23:0] w);
		i2c = 1'b0;
		ss_n_o = 1'b0;
		#37;
		for (int i = 23; i >= 0; i--) begin
			host_bit = w[i];
			#16 link_clk_o = 1'b1;
			#16 link_clk_o = 1'b0;
		end
		#20 ss_n_o = 1'b1;
		host_bit = ~host_bit;
		#200;
	endtask : spi_word

	// Byte MSB first then acknowledge clock; a frozen SCL holds the host back
	task automatic i2c_byte(input logic [7:0] b);
		i2c = 1'b1;
		ss_n_o = 1'b0;
		for (int i = 8; i >= 0; i--) begin
			host_bit = (i == 0) ? 1'b1 : b[i-1];
			#16;
			wait (!scl_oe_i);
			if (i == 0 && !sdata_o) n_ack++;
			link_clk_o = 1'b1;
			#16 link_clk_o = 1'b0;
		end
		#60;
	endtask : i2c_byte
endmodule : bml_partner
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the boot mode loader
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import bml_pkg::*;
	localparam logic [4:0] WAITS = 5'h03;
	logic         ref_clk_i = 1'b0;
	logic         reset_i = 1'b1;
	logic [2:0]   pins = 3'h0;
	bml_sw_cmd_t  sw_cmd = '0;
	logic [23:0]  fetch_addr = 24'h000000;
	logic [7:0]   ext_data, rom_index;
	logic [17:0]  ext_addr;
	logic         rd_n, aa1_n, link_clk, ss_n, sdata, sda_oe, scl_oe, rom_hit, run, busy, bad, hit;
	logic [23:0]  ocw, start_pc;
	bml_program_ram_wr_t program_ram_wr;
	logic [48:0]  exp_q[$];
	logic [48:0]  got, want;
	logic         frz = 1'b0;
	logic         run_q = 1'b0;
	logic [23:0]  rom_tab [0:4];
	int           miscompares = 0;
	int           n_compared = 0;
	int           cyc = 0;
	int           lo = 0;
	int           ea = 0;
	int unsigned  seed;

	initial forever #12.5 ref_clk_i = ~ref_clk_i;

	bml_boot_loader #(.EXT_WAITS(WAITS)) i_bml_boot_loader (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.link_clk_i(link_clk), .mode_pin_a_i(pins[0]), .mode_pin_b_i(pins[1]), .mode_pin_d_i(pins[2]),
		.sw_cmd_i(sw_cmd), .ext_data_i(ext_data), .ext_addr_o(ext_addr), .ext_rd_n_o(rd_n),
		.ext_aa1_n_o(aa1_n), .spi_ss_n_i(ss_n), .serial_data_i(sdata), .sda_o(), .sda_oe_o(sda_oe),
		.scl_o(), .scl_oe_o(scl_oe), .fetch_addr_i(fetch_addr), .rom_hit_o(rom_hit),
		.rom_index_o(rom_index), .program_ram_wr_o(program_ram_wr), .operating_control_word_o(ocw),
		.run_o(run), .start_pc_o(start_pc), .boot_busy_o(busy), .bad_mode_o(bad));

	bml_partner i_bml_partner (.ext_addr_i(ext_addr), .ext_rd_n_i(rd_n), .ext_data_o(ext_data),
		.sda_oe_i(sda_oe), .scl_oe_i(scl_oe), .link_clk_o(link_clk), .ss_n_o(ss_n), .sdata_o(sdata));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	task automatic do_boot(input logic [2:0] dba);
		@(negedge ref_clk_i);
		reset_i = 1'b1;
		pins = dba;
		frz = 1'b0;
		repeat (10) @(negedge ref_clk_i);
		check(ocw, 24'h000004);
		reset_i = 1'b0;
		repeat (2) @(negedge ref_clk_i);
		check(ocw, OCW_RESET);
		@(negedge ref_clk_i);
		check(ocw, {20'h00000, dba[2], 1'b1, dba[1:0]});
	endtask : do_boot

	task automatic load(input logic [3:0] mode, input int n);
		logic [23:0] s;
		logic [23:0] v[$];
		int          a0;
		s = 24'h000200 + 24'($urandom % 256);
		a0 = i_bml_partner.n_ack;
		v.push_back(24'(n));
		v.push_back(s);
		for (int i = 0; i < n; i++) begin
			v.push_back(24'($urandom));
			exp_q.push_back({1'b0, s + 24'(i), v[i+2]});
		end
		exp_q.push_back({1'b1, s, 24'h000000});
		foreach (v[k]) begin
			if (mode == 4'h5) for (int b = 0; b < 3; b++) i_bml_partner.mem[3*k+b] = v[k][8*b +: 8];
			else if (mode == 4'hd) i_bml_partner.spi_word(v[k]);
			else for (int b = 0; b < 3; b++) i_bml_partner.i2c_byte(v[k][8*b +: 8]);
		end
		if (mode[3:1] == 3'b111) check(i_bml_partner.n_ack - a0, 3 * (n + 2));
	endtask : load

	task automatic wait_done(input logic exp_run);
		for (int i = 0; i < 4000 && (exp_run ? run !== 1'b1 : bad !== 1'b1); i++) @(negedge ref_clk_i);
		repeat (3) @(negedge ref_clk_i);
		check({bad, busy, run}, exp_run ? 3'b001 : 3'b100);
		check(exp_q.size(), 0);
	endtask : wait_done

	////////////////////////////////////////////////////////////////////////////////
	// Results monitor: external strobes, program writes and the final jump
	always @(posedge ref_clk_i) begin
		#1;
		if (scl_oe) frz = 1'b1;
		if (reset_i || sw_cmd.jump) begin
			ea = 0;
			lo = 0;
		end else if (!rd_n) begin
			if (lo == 0) begin
				check({ext_addr, aa1_n}, {ea[17:0], 1'b0});
				ea++;
			end
			lo++;
		end else if (lo != 0) begin
			check({lo[7:0], aa1_n}, {8'(WAITS) + 8'h01, 1'b1});
			lo = 0;
		end
		if (program_ram_wr.we || (run && !run_q)) begin
			got = program_ram_wr.we ? {1'b0, program_ram_wr.addr, program_ram_wr.data} : {1'b1, start_pc, 24'h000000};
			want = (exp_q.size() != 0) ? exp_q.pop_front() : ~got;
			check(got, want);
		end
		run_q = run;
	end

	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			wrap_up;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = $urandom(96);
		rom_tab = '{24'hff0000, 24'hff00bf, 24'hff00c0, 24'hfeffff, 24'h000000};
		rom_tab[4] = ROM_FIRST + 24'($urandom % ROM_WORDS);
		exp_q.push_back({1'b1, RESET_VECTOR, 24'h000000});
		do_boot(3'b000);
		wait_done(1'b1);
		for (int k = 0; k < 5; k++) begin
			fetch_addr = rom_tab[k];
			@(negedge ref_clk_i);
			hit = (rom_tab[k] >= ROM_FIRST) && (rom_tab[k] <= ROM_LAST);
			check({rom_hit, hit ? rom_index : 8'h00}, {hit, hit ? rom_tab[k][7:0] : 8'h00});
		end
		load(4'h5, 3);
		do_boot(3'b001);
		wait_done(1'b1);
		do_boot(3'b101);
		load(4'hd, 2);
		wait_done(1'b1);
		do_boot(3'b110);
		load(4'he, 2);
		wait_done(1'b1);
		check(frz, 1'b1);
		do_boot(3'b111);
		load(4'hf, 1);
		wait_done(1'b1);
		check(frz, 1'b0);
		for (int k = 2; k <= 4; k++) begin
			do_boot(3'(k));
			wait_done(1'b0);
		end
		// Reboot from the halted state into the byte loader with an empty program
		load(4'h5, 0);
		sw_cmd = '{wr: 1'b1, bits: 4'h5, jump: 1'b1};
		@(negedge ref_clk_i);
		sw_cmd = '0;
		@(negedge ref_clk_i);
		check(ocw, 24'h000005);
		wait_done(1'b1);
		wrap_up;
	end
endmodule : testbench
`default_nettype wire
